// file: vtf_pkg.sv
// Purpose: Shared constants and types for the VLAN tag filter.
// Assumes: Byte-wide frame streams without FCS on ingress.
// Notes: Eight ports, 12-bit VLAN identifiers.
package vtf_pkg;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 3;
    localparam int VID_W = 12;
    localparam int TBL_DEPTH = 4096;
    localparam int HDR_BYTES = 14;
    localparam logic [12:0] INIT_LAST = 13'h0FFF;
    localparam logic [15:0] TPID = 16'h8100;
    localparam logic [11:0] FACTORY_VID = 12'h001;
    localparam logic [11:0] VID_NULL = 12'h000;
    localparam logic [11:0] VID_RSVD = 12'hFFF;
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic CFI_BUILD = 1'b0;
    localparam logic [4:0] IDX_TYPE_HI = 5'h0C;
    localparam logic [4:0] IDX_TYPE_LO = 5'h0D;
    localparam logic [4:0] IDX_TCI_HI = 5'h0E;
    localparam logic [4:0] IDX_TCI_LO = 5'h0F;
    localparam logic [4:0] IDX_COPY_HI = 5'h10;
    localparam logic [4:0] IDX_COPY_LO = 5'h11;
    localparam logic [4:0] IDX_FCS_LAST = 5'h03;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    typedef enum logic [3:0] {
        VTF_INIT = 4'b0000,
        VTF_IDLE = 4'b0001,
        VTF_HEAD = 4'b0010,
        VTF_TCI = 4'b0011,
        VTF_DECIDE = 4'b0100,
        VTF_EMIT = 4'b0101,
        VTF_BODY = 4'b0110,
        VTF_FCS = 4'b0111,
        VTF_DROP = 4'b1000
    } vtf_state_t;
endpackage

// file: vtf_crc32.sv
// Purpose: Byte-serial Ethernet CRC-32 over the egress stream.
// Assumes: Reflected polynomial, bytes least significant bit first.
// Notes: Output is the raw register; the caller inverts it for the FCS.
`timescale 1ns/100ps
module vtf_crc32
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Byte feed.
    input wire logic clear_in,
    input wire logic en_in,
    input wire logic [7:0] data_in,
    // Running remainder.
    output logic [31:0] crc_out
);
    import vtf_pkg::*;

    logic [31:0] crc_q;
    logic [31:0] crc_d;

    always_comb
    begin
        crc_d = crc_q;
        if (clear_in)
        begin
            crc_d = CRC_INIT;
        end
        else if (en_in)
        begin
            crc_d = crc_q ^ {24'h000000, data_in};
            for (int i = 0; i < 8; i++)
            begin
                crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            crc_q <= CRC_INIT;
        end
        else
        begin
            crc_q <= crc_d;
        end
    end

    assign crc_out = crc_q;
endmodule // vtf_crc32

// file: vtf_tagger.sv
// Purpose: Per-port 802.1Q classification, membership filter and egress tagging.
// Assumes: One frame at a time; destination port comes from the forwarding table.
// Notes: Ingress stream carries no FCS; a fresh FCS is appended on egress.
// What this block does
// [R1] A frame is tagged only when the type after the source address is 0x8100.
// [R2] The tag is four octets right after the source address; other fields kept.
// [R3] Tag control holds 3-bit priority, 1-bit format flag, 12-bit VLAN identifier.
// [R4] Inserted tag goes before the length/type field; FCS recomputed over the result.
// [R5] VLANs are told apart by the 12-bit identifier, up to 4094 values.
// [R6] After reset every port is in the factory VLAN and has PVID 1.
// [R7] Untagged frames are classified and forwarded by the receiving port's PVID.
// [R8] Tagged frames are forwarded by the identifier in their tag.
// [R9] A frame whose VLAN the outgoing port lacks is discarded.
// [R10] One PVID per port; memberships limited only by the table size.
// [R11] Frames of any kind reach only member ports of their VLAN.
// [R12] Memberships may overlap; a port may join many VLANs.
// [R13] Each port independently selects tagging or untagging.
// [R14] Tagging ports add a tag to untagged frames; tagged frames pass unchanged.
// [R15] Untagging ports strip tags; no frame leaves them tagged.
// [R16] Handling runs ingress classification, forward-or-filter, then egress tagging.
// [R17] Only single-level 802.1Q tagging is used, no address-based classification.
// [R18] With ingress filtering, tagged frames drop if the receiving port is not member.
// [R19] Built tags carry the receiving port's PVID and a zero format flag.
`timescale 1ns/100ps
module vtf_tagger
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Ingress byte stream.
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_last_in,
    input wire logic [vtf_pkg::PORT_W-1:0] rx_port_in,
    input wire logic [vtf_pkg::PORT_W-1:0] rx_dst_in,
    output logic rx_ready_out,
    // Egress byte stream.
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    output logic tx_last_out,
    output logic [vtf_pkg::PORT_W-1:0] tx_port_out,
    // Port configuration.
    input wire logic cfg_pvid_we_in,
    input wire logic [vtf_pkg::PORT_W-1:0] cfg_port_in,
    input wire logic [vtf_pkg::VID_W-1:0] cfg_pvid_in,
    input wire logic [2:0] cfg_prio_in,
    input wire logic cfg_member_we_in,
    input wire logic [vtf_pkg::VID_W-1:0] cfg_vid_in,
    input wire logic [vtf_pkg::NUM_PORTS-1:0] cfg_member_in,
    input wire logic [vtf_pkg::NUM_PORTS-1:0] tag_mode_in,
    input wire logic [vtf_pkg::NUM_PORTS-1:0] ingress_filter_in,
    // Status.
    output logic busy_out,
    output logic drop_out,
    output logic [vtf_pkg::VID_W-1:0] frame_vid_out
);
    import vtf_pkg::*;

    // [R5] Usable identifier check.
    function automatic logic vid_usable(input logic [VID_W-1:0] v);
        vid_usable = (v != VID_NULL) && (v != VID_RSVD);
    endfunction

    function automatic logic member_of(input logic [NUM_PORTS-1:0] m,
                                       input logic [PORT_W-1:0] p);
        member_of = m[p];
    endfunction

    logic [NUM_PORTS-1:0] member_mem [0:TBL_DEPTH-1];
    vtf_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [7:0] hdr_q [0:HDR_BYTES-1];
    logic [7:0] hdr_d [0:HDR_BYTES-1];
    logic [15:0] tci_q, tci_d;
    logic tagged_q, tagged_d;
    logic tag_out_q, tag_out_d;
    logic [PORT_W-1:0] src_q, src_d, dst_q, dst_d;
    logic [12:0] init_q, init_d;
    logic [VID_W-1:0] pvid_q [0:NUM_PORTS-1];
    logic [VID_W-1:0] pvid_d [0:NUM_PORTS-1];
    logic [2:0] prio_q [0:NUM_PORTS-1];
    logic [2:0] prio_d [0:NUM_PORTS-1];
    logic rx_ready_q, rx_ready_d;
    logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic busy_q, busy_d, drop_q, drop_d;
    logic [VID_W-1:0] vid_q, vid_d;
    logic [VID_W-1:0] vid_sel;
    logic [NUM_PORTS-1:0] vid_members;
    logic frame_ok;
    logic take;
    logic [4:0] cnt_inc;
    logic [31:0] crc_val;
    logic crc_clear, crc_en;

    assign take = rx_valid_in && rx_ready_q;
    assign cnt_inc = cnt_q + 5'h01;

    // [R7] [R8] Classification source.
    assign vid_sel = tagged_q ? tci_q[VID_W-1:0] : pvid_q[src_q];
    assign vid_members = member_mem[vid_sel];
    // [R9] [R11] [R18] Filter decision.
    assign frame_ok = vid_usable(vid_sel) && member_of(vid_members, dst_q)
        && !(tagged_q && ingress_filter_in[src_q] && !member_of(vid_members, src_q));

    // [R6] [R10] [R12] Membership table writes.
    always_ff @(posedge clk_in)
    begin
        if (state_q == VTF_INIT)
        begin
            member_mem[init_q[VID_W-1:0]] <= (init_q[VID_W-1:0] == FACTORY_VID) ?
                {NUM_PORTS{1'b1}} : {NUM_PORTS{1'b0}};
        end
        else if (cfg_member_we_in && vid_usable(cfg_vid_in))
        begin
            member_mem[cfg_vid_in] <= cfg_member_in;
        end
    end

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        tci_d = tci_q;
        tagged_d = tagged_q;
        tag_out_d = tag_out_q;
        src_d = src_q;
        dst_d = dst_q;
        init_d = init_q;
        pvid_d = pvid_q;
        prio_d = prio_q;
        tx_valid_d = 1'b0;
        tx_last_d = 1'b0;
        tx_data_d = tx_data_q;
        drop_d = 1'b0;
        vid_d = vid_q;
        if (cfg_pvid_we_in && vid_usable(cfg_pvid_in))
        begin
            pvid_d[cfg_port_in] = cfg_pvid_in;
            prio_d[cfg_port_in] = cfg_prio_in;
        end
        // [R16] Ingress, filter and egress stages in sequence.
        case (state_q)
            VTF_INIT:
            begin
                init_d = init_q + 13'h0001;
                if (init_q == INIT_LAST)
                begin
                    state_d = VTF_IDLE;
                end
            end
            VTF_IDLE:
            begin
                cnt_d = 5'h00;
                if (take)
                begin
                    hdr_d[0] = rx_data_in;
                    src_d = rx_port_in;
                    dst_d = rx_dst_in;
                    tagged_d = 1'b0;
                    cnt_d = 5'h01;
                    state_d = rx_last_in ? VTF_IDLE : VTF_HEAD;
                    drop_d = rx_last_in;
                end
            end
            VTF_HEAD:
            begin
                if (take)
                begin
                    hdr_d[cnt_q[3:0]] = rx_data_in;
                    cnt_d = cnt_inc;
                    if (rx_last_in)
                    begin
                        drop_d = 1'b1;
                        state_d = VTF_IDLE;
                    end
                    else if (cnt_q == IDX_TYPE_LO)
                    begin
                        // [R1] [R17] Single tag level detected by TPID.
                        tagged_d = ({hdr_q[IDX_TYPE_HI[3:0]], rx_data_in} == TPID);
                        state_d = tagged_d ? VTF_TCI : VTF_DECIDE;
                    end
                end
            end
            VTF_TCI:
            begin
                if (take)
                begin
                    cnt_d = cnt_inc;
                    // [R3] Tag control parsed as one word.
                    if (cnt_q == IDX_TCI_HI)
                    begin
                        tci_d[15:8] = rx_data_in;
                    end
                    else
                    begin
                        tci_d[7:0] = rx_data_in;
                        state_d = VTF_DECIDE;
                    end
                    if (rx_last_in)
                    begin
                        drop_d = 1'b1;
                        state_d = VTF_IDLE;
                    end
                end
            end
            VTF_DECIDE:
            begin
                vid_d = vid_sel;
                // [R13] Per-port egress mode.
                tag_out_d = tag_mode_in[dst_q];
                cnt_d = 5'h00;
                if (!tagged_q)
                begin
                    // [R19] Built tag fields.
                    tci_d = {prio_q[src_q], CFI_BUILD, pvid_q[src_q]};
                end
                state_d = frame_ok ? VTF_EMIT : VTF_DROP;
                drop_d = !frame_ok;
            end
            VTF_EMIT:
            begin
                tx_valid_d = 1'b1;
                cnt_d = cnt_inc;
                case (cnt_q)
                    IDX_TYPE_HI: tx_data_d = TPID[15:8];
                    IDX_TYPE_LO: tx_data_d = TPID[7:0];
                    IDX_TCI_HI: tx_data_d = tci_q[15:8];
                    IDX_TCI_LO: tx_data_d = tci_q[7:0];
                    IDX_COPY_HI: tx_data_d = hdr_q[IDX_TYPE_HI[3:0]];
                    IDX_COPY_LO: tx_data_d = hdr_q[IDX_TYPE_LO[3:0]];
                    default: tx_data_d = hdr_q[cnt_q[3:0]];
                endcase
                // [R2] [R4] [R14] [R15] Tag inserted or skipped before type.
                if (cnt_inc == IDX_TYPE_HI && !tag_out_q)
                begin
                    cnt_d = IDX_COPY_HI;
                end
                if ((cnt_d == IDX_COPY_HI && tagged_q) || cnt_q == IDX_COPY_LO)
                begin
                    state_d = VTF_BODY;
                end
            end
            VTF_BODY:
            begin
                cnt_d = 5'h00;
                if (take)
                begin
                    tx_valid_d = 1'b1;
                    tx_data_d = rx_data_in;
                    state_d = rx_last_in ? VTF_FCS : VTF_BODY;
                end
            end
            VTF_FCS:
            begin
                // [R4] Fresh FCS, low byte first.
                tx_valid_d = 1'b1;
                tx_data_d = ~crc_val[cnt_q[1:0]*8 +: 8];
                cnt_d = cnt_inc;
                if (cnt_q == IDX_FCS_LAST)
                begin
                    tx_last_d = 1'b1;
                    state_d = VTF_IDLE;
                end
            end
            VTF_DROP:
            begin
                if (take && rx_last_in)
                begin
                    state_d = VTF_IDLE;
                end
            end
            default:
            begin
                state_d = VTF_IDLE;
            end
        endcase
        rx_ready_d = (state_d == VTF_IDLE) || (state_d == VTF_HEAD) ||
            (state_d == VTF_TCI) || (state_d == VTF_BODY) || (state_d == VTF_DROP);
        busy_d = (state_d == VTF_INIT);
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_q <= VTF_INIT;
            cnt_q <= 5'h00;
            tci_q <= 16'h0000;
            tagged_q <= 1'b0;
            tag_out_q <= 1'b0;
            src_q <= '0;
            dst_q <= '0;
            init_q <= 13'h0000;
            rx_ready_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            tx_data_q <= 8'h00;
            busy_q <= 1'b1;
            drop_q <= 1'b0;
            vid_q <= VID_NULL;
            for (int i = 0; i < HDR_BYTES; i++)
            begin
                hdr_q[i] <= 8'h00;
            end
            // [R6] Factory PVID on every port.
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                pvid_q[p] <= FACTORY_VID;
                prio_q[p] <= PRIO_RST;
            end
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            tci_q <= tci_d;
            tagged_q <= tagged_d;
            tag_out_q <= tag_out_d;
            src_q <= src_d;
            dst_q <= dst_d;
            init_q <= init_d;
            rx_ready_q <= rx_ready_d;
            tx_valid_q <= tx_valid_d;
            tx_last_q <= tx_last_d;
            tx_data_q <= tx_data_d;
            busy_q <= busy_d;
            drop_q <= drop_d;
            vid_q <= vid_d;
            hdr_q <= hdr_d;
            pvid_q <= pvid_d;
            prio_q <= prio_d;
        end
    end

    assign crc_clear = (state_q == VTF_IDLE);
    assign crc_en = tx_valid_d && (state_q != VTF_FCS);

    vtf_crc32 u_crc
    (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clear_in(crc_clear),
        .en_in(crc_en),
        .data_in(tx_data_d),
        .crc_out(crc_val)
    );

    assign rx_ready_out = rx_ready_q;
    assign tx_valid_out = tx_valid_q;
    assign tx_data_out = tx_data_q;
    assign tx_last_out = tx_last_q;
    assign tx_port_out = dst_q;
    assign busy_out = busy_q;
    assign drop_out = drop_q;
    assign frame_vid_out = vid_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_tpid_out;
        tx_data_out == TPID[15:8] ##1 tx_data_out == TPID[7:0];
    endsequence

    a_tpid_detect: assert property ( // [R1]
        (state_q == VTF_HEAD && take && cnt_q == IDX_TYPE_LO && !rx_last_in &&
         {hdr_q[IDX_TYPE_HI[3:0]], rx_data_in} == TPID) |=> state_q == VTF_TCI)
        else $error("TPID frame did not enter tag parsing");

    a_tag_insert: assert property ( // [R2]
        (state_q == VTF_EMIT && cnt_q == IDX_TYPE_HI) |=> s_tpid_out)
        else $error("Inserted tag does not start with TPID");

    a_built_tci: assert property ( // [R19]
        (state_q == VTF_DECIDE && !tagged_q) |=>
        (tci_q[12] == CFI_BUILD && tci_q[11:0] == $past(pvid_q[src_q])))
        else $error("Built tag fields wrong");

    a_type_after: assert property ( // [R4]
        (state_q == VTF_EMIT && cnt_q == IDX_COPY_HI) |=>
        tx_data_out == hdr_q[IDX_TYPE_HI[3:0]])
        else $error("Length/type not placed after tag");

    a_fcs_tail: assert property ( // [R4]
        (state_q == VTF_BODY && take && rx_last_in) |=> !tx_last_out ##4 tx_last_out)
        else $error("FCS tail not four bytes");

    a_dst_filter: assert property ( // [R9]
        (state_q == VTF_DECIDE && !member_of(vid_members, dst_q)) |=>
        (drop_out && state_q == VTF_DROP))
        else $error("Non-member destination not dropped");

    a_ingress_filt: assert property ( // [R18]
        (state_q == VTF_DECIDE && tagged_q && ingress_filter_in[src_q] &&
         !member_of(vid_members, src_q)) |=> drop_out)
        else $error("Ingress filter did not drop");

    a_untag_strip: assert property ( // [R15]
        (state_q == VTF_EMIT && !tag_out_q) |->
        !(cnt_q >= IDX_TYPE_HI && cnt_q <= IDX_TCI_LO))
        else $error("Tag emitted on untagging port");

    a_vid_class: assert property ( // [R8]
        (state_q == VTF_DECIDE) |=>
        frame_vid_out == ($past(tagged_q) ? $past(tci_q[11:0]) : $past(pvid_q[src_q])))
        else $error("Frame VLAN chosen from wrong source");
endmodule // vtf_tagger

// file: vtf_link_sink.sv
// Purpose: Far-side station that receives the egress stream of the tag filter.
// Assumes: No back-pressure; every valid byte is accepted.
// Notes: Reports each frame end and whether its FCS residue is correct.
`timescale 1ns/100ps
module vtf_link_sink
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Egress stream.
    input wire logic valid_in,
    input wire logic [7:0] data_in,
    input wire logic last_in,
    // Frame result.
    output logic done_out,
    output logic crc_ok_out
);
    logic [31:0] crc_q;
    logic [31:0] nxt;

    function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h000000, d};
        for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
        return c;
    endfunction

    always @(posedge clk_in)
    begin
        done_out <= 1'b0;
        if (reset_in)
        begin
            crc_q <= 32'hFFFFFFFF;
            crc_ok_out <= 1'b0;
        end
        else if (valid_in)
        begin
            nxt = step(crc_q, data_in);
            crc_q <= last_in ? 32'hFFFFFFFF : nxt;
            if (last_in)
            begin
                done_out <= 1'b1;
                crc_ok_out <= (nxt == 32'hDEBB20E3);
            end
        end
    end
endmodule // vtf_link_sink

// file: vtf_tagger_test.sv
// Purpose: Self-checking bench for the VLAN tag filter.
// Assumes: One frame in flight at a time.
// Notes: Expected bytes come from a model of the tables kept here.
`timescale 1ns/100ps
module vtf_tagger_test;
    import vtf_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic rx_valid_in = 1'b0;
    logic [7:0] rx_data_in = 8'h00;
    logic rx_last_in = 1'b0;
    logic [PORT_W-1:0] rx_port_in = 3'h0;
    logic [PORT_W-1:0] rx_dst_in = 3'h0;
    logic cfg_pvid_we_in = 1'b0;
    logic [PORT_W-1:0] cfg_port_in = 3'h0;
    logic [VID_W-1:0] cfg_pvid_in = 12'h000;
    logic [2:0] cfg_prio_in = 3'h0;
    logic cfg_member_we_in = 1'b0;
    logic [VID_W-1:0] cfg_vid_in = 12'h000;
    logic [NUM_PORTS-1:0] cfg_member_in = 8'h00;
    logic [NUM_PORTS-1:0] tag_mode_in = 8'h00;
    logic [NUM_PORTS-1:0] ingress_filter_in = 8'h00;
    logic rx_ready_out, tx_valid_out, tx_last_out, busy_out, drop_out, done_w, ok_w;
    logic [7:0] tx_data_out;
    logic [PORT_W-1:0] tx_port_out;
    logic [VID_W-1:0] frame_vid_out;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h52EF65DB;
    logic [9:0] exp_q [$];
    logic [7:0] fr [$];
    logic [7:0] mem_m [0:4095];
    logic [11:0] pvid_m [0:7];
    logic [2:0] prio_m [0:7];

    vtf_tagger u_dut (.clk_in(clk_in), .reset_in(reset_in), .rx_valid_in(rx_valid_in),
        .rx_data_in(rx_data_in), .rx_last_in(rx_last_in), .rx_port_in(rx_port_in),
        .rx_dst_in(rx_dst_in), .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .tx_last_out(tx_last_out), .tx_port_out(tx_port_out),
        .cfg_pvid_we_in(cfg_pvid_we_in), .cfg_port_in(cfg_port_in),
        .cfg_pvid_in(cfg_pvid_in), .cfg_prio_in(cfg_prio_in),
        .cfg_member_we_in(cfg_member_we_in), .cfg_vid_in(cfg_vid_in),
        .cfg_member_in(cfg_member_in), .tag_mode_in(tag_mode_in),
        .ingress_filter_in(ingress_filter_in), .busy_out(busy_out), .drop_out(drop_out),
        .frame_vid_out(frame_vid_out));
    vtf_link_sink u_sink (.clk_in(clk_in), .reset_in(reset_in), .valid_in(tx_valid_out),
        .data_in(tx_data_out), .last_in(tx_last_out), .done_out(done_w), .crc_ok_out(ok_w));

    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic set_cfg(input logic pv, input logic [2:0] p, input logic [11:0] v,
                           input logic [2:0] pr, input logic [7:0] m);
        cfg_pvid_we_in = pv;
        cfg_member_we_in = !pv;
        cfg_port_in = p;
        cfg_pvid_in = v;
        cfg_vid_in = v;
        cfg_prio_in = pr;
        cfg_member_in = m;
        @(negedge clk_in);
        cfg_pvid_we_in = 1'b0;
        cfg_member_we_in = 1'b0;
        if (v != VID_NULL && v != VID_RSVD)
        begin
            if (pv)
            begin
                pvid_m[p] = v;
                prio_m[p] = pr;
            end
            else
                mem_m[v] = m;
        end
        @(negedge clk_in);
    endtask

    task automatic mk(input logic tg, input logic [15:0] typ, input logic [15:0] tci,
                      input int n);
        fr = {};
        for (int i = 0; i < 12; i++)
            fr.push_back(rnd() >> 8);
        if (tg)
            fr = {fr, 8'h81, 8'h00, tci[15:8], tci[7:0]};
        fr = {fr, typ[15:8], typ[7:0]};
        for (int i = 0; i < n; i++)
            fr.push_back(rnd() >> 8);
    endtask

    task automatic send(input logic [2:0] src, input logic [2:0] dst);
        logic [7:0] o [$];
        logic tg, rdy;
        logic [11:0] vid;
        logic [31:0] c;
        int n;
        o = fr;
        n = fr.size();
        tg = n >= 14 && {fr[12], fr[13]} == TPID;
        vid = tg ? {fr[14][3:0], fr[15]} : pvid_m[src];
        if (n < 15 || (tg && n < 17) || vid == VID_NULL || vid == VID_RSVD || !mem_m[vid][dst]
            || (tg && ingress_filter_in[src] && !mem_m[vid][src]))
            exp_q.push_back(10'h200);
        else
        begin
            if (tg && !tag_mode_in[dst])
                repeat (4) o.delete(12);
            if (!tg && tag_mode_in[dst])
            begin
                o.insert(12, vid[7:0]);
                o.insert(12, {prio_m[src], CFI_BUILD, vid[11:8]});
                o.insert(12, 8'h00);
                o.insert(12, 8'h81);
            end
            c = CRC_INIT;
            foreach (o[i])
            begin
                c = c ^ {24'h000000, o[i]};
                repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
            c = ~c;
            o = {o, c[7:0], c[15:8], c[23:16], c[31:24]};
            foreach (o[i])
                exp_q.push_back({1'b0, i == o.size() - 1, o[i]});
        end
        rx_port_in = src;
        rx_dst_in = dst;
        for (int i = 0; i < n; i++)
        begin
            rx_valid_in = 1'b1;
            rx_data_in = fr[i];
            rx_last_in = (i == n - 1);
            do
            begin
                rdy = rx_ready_out;
                @(negedge clk_in);
            end while (!rdy);
        end
        rx_valid_in = 1'b0;
        rx_last_in = 1'b0;
        for (int k = 0; k < 300 && exp_q.size() != 0; k++)
            @(negedge clk_in);
        check("queue drained", exp_q.size(), 0);
        check("egress port", tx_port_out, dst);
        if (!(n < 15 || (tg && n < 17)))
            check("frame vlan", frame_vid_out, vid);
        repeat (3) @(negedge clk_in);
    endtask

    // Watcher takes the oldest note for each output event.
    always @(negedge clk_in)
    begin
        logic [9:0] e;
        if (!reset_in && (tx_valid_out === 1'b1 || drop_out === 1'b1))
        begin
            check("note waiting", exp_q.size() != 0, 1'b1);
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
            check("event kind", {drop_out, tx_valid_out}, e[9] ? 2'b10 : 2'b01);
            if (!e[9])
            begin
                check("tx byte", tx_data_out, e[7:0]);
                check("tx last", tx_last_out, e[8]);
            end
        end
        if (done_w === 1'b1)
            check("fcs residue", ok_w, 1'b1);
    end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        foreach (mem_m[v])
            mem_m[v] = 8'h00;
        mem_m[1] = 8'hFF;
        foreach (pvid_m[p])
        begin
            pvid_m[p] = FACTORY_VID;
            prio_m[p] = PRIO_RST;
        end
        repeat (4) @(negedge clk_in);
        reset_in = 1'b0;
        @(negedge clk_in);
        check("init ready", {busy_out, rx_ready_out}, 2'b10);
        for (int k = 0; k < 5000 && busy_out !== 1'b0; k++)
            @(negedge clk_in);
        check("init done", {busy_out, rx_ready_out}, 2'b01);
        tag_mode_in = 8'h20;
        mk(1'b0, 16'h0800, 16'h0000, 5);
        send(3'h2, 3'h5);
        send(3'h2, 3'h4);
        $display("factory VLAN done");
        set_cfg(1'b0, 3'h0, 12'h123, 3'h0, 8'h0A);
        set_cfg(1'b1, 3'h1, 12'h123, 3'h5, 8'h00);
        set_cfg(1'b1, 3'h2, 12'hFFF, 3'h1, 8'h00);
        tag_mode_in = 8'h08;
        send(3'h1, 3'h3);
        send(3'h1, 3'h4);
        mk(1'b0, 16'h8101, 16'h0000, 3);
        send(3'h2, 3'h3);
        $display("classification done");
        mk(1'b1, 16'h0800, 16'h6123, 4);
        send(3'h6, 3'h3);
        tag_mode_in = 8'h00;
        send(3'h6, 3'h3);
        send(3'h6, 3'h4);
        ingress_filter_in = 8'h40;
        send(3'h6, 3'h3);
        send(3'h1, 3'h3);
        mk(1'b1, 16'h0800, 16'h2FFF, 4);
        send(3'h1, 3'h3);
        mk(1'b0, 16'h0800, 16'h0000, 0);
        repeat (4) void'(fr.pop_back());
        send(3'h0, 3'h1);
        $display("tagged and drop cases done");
        for (int t = 0; t < 12; t++)
        begin
            tag_mode_in = rnd() >> 4;
            mk(rnd() > 32'h80000000, 16'h0800, {3'h2, 1'b0, 12'h001}, 1 + (rnd() & 7));
            send(rnd() >> 3, rnd() >> 7);
        end
        $display("random frames done");
        test_done();
    end
endmodule // vtf_tagger_test
